/* File: hdl/machine_check_bus_init_escalation.sv */
// Escalation of bus-interface faults to machine check, bus reinit or shutdown
//
// Overview of operation
// - Second machine check while one is outstanding shuts down, holds internal fault.
// - Bus reinit seen with machine checks disabled causes shutdown, no handler.
// - Without machine check enable, never invoke handler; fatal errors shut down.
// - Observe-disable option makes the unit ignore incoming bus reinit.
// - Drive-disable option keeps the unit from ever asserting bus reinit.
// - Double-bit read ECC fault with checks enabled raises handled machine check.
// - Bus reinit seen outside shutdown clears bus interface state and drops outstanding work.
// - Unattributable error in run state drives bus reinit instead of raising machine check; with one outstanding it shuts down.
// - Logged cache level field is 01 for first level, 10 for second.
`timescale 1ns/100ps
module machine_check_bus_init_escalation
	import mc_escalation_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       resetn,
	// Configuration
	input  wire logic       cfg_load,
	input  wire cfg_s       cfg_in,
	// Faults from bus interface
	input  wire fault_s     fault,
	// Handler returns from machine check
	input  wire logic       mc_done,
	// Shared bus reinit line
	input  wire logic       bus_reinit_n_in,
	output logic            bus_reinit_n_out,
	output logic            bus_reinit_n_oe,
	// Core side
	output logic            machine_check_event,
	output logic            internal_fault_n,
	output logic            bus_iface_clear,
	output logic            halted,
	output logic [1:0]      cache_level_field,
	output cfg_s            cfg_out
);
	logic   [2:0] sync_ff;
	logic         reinit_seen_ff;
	cfg_s         cfg_ff;
	cfg_s         nxt_cfg;
	state_e       state_ff;
	state_e       nxt_state;
	logic         mce_ff;
	logic         nxt_mce;
	logic         drive_ff;
	logic         nxt_drive;
	logic         clear_ff;
	logic         nxt_clear;
	logic         internal_fault_n_n_ff;
	logic         nxt_internal_fault_n_n;
	logic   [1:0] level_ff;
	logic   [1:0] nxt_level;
	logic         nxt_reinit_seen;
	logic         reinit_in;
	logic         mc_raise;
	logic         fatal;
	logic         reinit_edge;
	logic         reinit_prev_ff;
	logic   [1:0] level_code;
	logic         halted_ff;
	logic         nxt_halted;
	logic         out_ff;
	logic         nxt_out;

	// Pin synchroniser, change taken once stages two and three agree
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync_ff        <= 3'h7;
			reinit_seen_ff <= 1'h0;
			reinit_prev_ff <= 1'h0;
		end else begin
			sync_ff        <= {sync_ff[1:0], bus_reinit_n_in};
			reinit_seen_ff <= nxt_reinit_seen;
			reinit_prev_ff <= reinit_in;
		end
	end

	always_comb begin
		nxt_reinit_seen = reinit_seen_ff;
		if (sync_ff[2] == sync_ff[1])
			nxt_reinit_seen = ~sync_ff[1];
	end

	// Observe gating; a held line is one assertion, not one per cycle
	always_comb begin
		reinit_in   = reinit_seen_ff & ~cfg_ff.observe_off;
		reinit_edge = reinit_in & ~reinit_prev_ff;
	end

	// Fault source decode
	always_comb begin
		mc_raise = fault.ecc_double | fault.cache_err | reinit_edge;
		fatal    = fault.async_fatal | fault.ecc_double | fault.cache_err;
	end

	// Cache level encoding
	always_comb begin
		level_code = LEVEL_NONE;
		if (fault.cache_err)
			level_code = fault.cache_l2 ? LEVEL_L2 : LEVEL_L1;
	end

	// Configuration register
	always_comb begin
		nxt_cfg = cfg_ff;
		if (cfg_load)
			nxt_cfg = cfg_in;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			cfg_ff <= '{CFG_RST, CFG_RST, CFG_RST};
		else
			cfg_ff <= nxt_cfg;
	end

	// Escalation state machine
	always_comb begin
		nxt_state  = state_ff;
		nxt_mce    = 1'h0;
		nxt_drive  = 1'h0;
		nxt_clear  = 1'h0;
		nxt_internal_fault_n_n = internal_fault_n_n_ff;
		nxt_level  = level_ff;
		unique case (state_ff)
			ST_RUN, ST_MC_PENDING: begin
				if (reinit_in)
					nxt_clear = 1'h1;
				if (fault.ambiguous && state_ff == ST_RUN) begin
					nxt_drive = ~cfg_ff.drive_off;
					nxt_clear = 1'h1;
					if (cfg_ff.drive_off) begin
						nxt_state  = ST_SHUTDOWN;
						nxt_internal_fault_n_n = 1'h0;
					end
				end else if (!cfg_ff.mc_enable) begin
					if (reinit_in || fatal || fault.ambiguous) begin
						nxt_state  = ST_SHUTDOWN;
						nxt_internal_fault_n_n = 1'h0;
					end
				end else if (state_ff == ST_MC_PENDING) begin
					if (mc_raise || fault.async_fatal || fault.ambiguous) begin
						nxt_state  = ST_SHUTDOWN;
						nxt_internal_fault_n_n = 1'h0;
					end else if (mc_done) begin
						nxt_state = ST_RUN;
					end
				end else if (mc_raise || fault.async_fatal) begin
					nxt_state = ST_MC_PENDING;
					nxt_mce   = 1'h1;
					nxt_level = level_code;
				end
			end
			ST_SHUTDOWN: begin
				nxt_internal_fault_n_n = 1'h0;
			end
			default: begin
				nxt_state  = ST_SHUTDOWN;
				nxt_internal_fault_n_n = 1'h0;
			end
		endcase
	end

	// Next values of shutdown flag and open-drain data
	always_comb begin
		nxt_halted = (nxt_state == ST_SHUTDOWN);
		nxt_out    = 1'h0;
	end

	// Output flops for shutdown flag and open-drain data
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			halted_ff <= 1'h0;
			out_ff    <= 1'h0;
		end else begin
			halted_ff <= nxt_halted;
			out_ff    <= nxt_out;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_ff  <= ST_RUN;
			mce_ff    <= 1'h0;
			drive_ff  <= 1'h0;
			clear_ff  <= 1'h0;
			internal_fault_n_n_ff <= 1'h1;
			level_ff  <= LEVEL_RST;
		end else begin
			state_ff  <= nxt_state;
			mce_ff    <= nxt_mce;
			drive_ff  <= nxt_drive;
			clear_ff  <= nxt_clear;
			internal_fault_n_n_ff <= nxt_internal_fault_n_n;
			level_ff  <= nxt_level;
		end
	end

	// Outputs from flip-flops
	assign bus_reinit_n_out    = out_ff;
	assign bus_reinit_n_oe     = drive_ff;
	assign machine_check_event = mce_ff;
	assign internal_fault_n    = internal_fault_n_n_ff;
	assign bus_iface_clear     = clear_ff;
	assign halted              = halted_ff;
	assign cache_level_field   = level_ff;
	assign cfg_out             = cfg_ff;
endmodule : machine_check_bus_init_escalation

/* File: hdl/mc_escalation_pkg.sv */
// Package with types and constants for the bus-error escalation unit
package mc_escalation_pkg;
	// Cache level field encodings
	localparam logic [1:0] LEVEL_L1     = 2'h1;
	localparam logic [1:0] LEVEL_L2     = 2'h2;
	localparam logic [1:0] LEVEL_NONE   = 2'h0;
	// Reset values of configuration and log
	localparam logic       CFG_RST      = 1'h0;
	localparam logic [1:0] LEVEL_RST    = 2'h0;
	localparam int         CFG_W        = 3;

	// Error source indications from the bus interface
	typedef struct packed {
		logic       ecc_double;
		logic       ambiguous;
		logic       async_fatal;
		logic       cache_err;
		logic       cache_l2;
	} fault_s;

	// Configuration settings
	typedef struct packed {
		logic       mc_enable;
		logic       observe_off;
		logic       drive_off;
	} cfg_s;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_MC_PENDING,
		ST_SHUTDOWN
	} state_e;
endpackage : mc_escalation_pkg

/* File: test/partner_agent.sv */
// Other bus agents on the open-drain reinit line
`timescale 1ns/100ps
module partner_agent (
	// Line drivers and wire
	input  wire logic oe,
	input  wire logic drv,
	input  wire logic req,
	output wire logic line
);
	assign line = ((oe && !drv) || req) ? 1'b0 : 1'b1;
endmodule : partner_agent

/* File: test/mce_monitor.sv */
// Assertion checker for the escalation unit
`timescale 1ns/100ps
module mce_monitor
	import mc_escalation_pkg::*;
(
	// Watched ports
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic       cfg_load,
	input wire cfg_s       cfg_out,
	input wire fault_s     fault,
	input wire logic       bus_reinit_n_oe,
	input wire logic       machine_check_event,
	input wire logic       internal_fault_n,
	input wire logic       halted,
	input wire logic [1:0] cache_level_field
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence s_down; halted && !internal_fault_n; endsequence
	property p_hold; halted |=> s_down; endproperty
	a_hold: assert property (p_hold) else $error("left shutdown");
	property p_off; !cfg_out.mc_enable |=> !machine_check_event; endproperty
	a_off: assert property (p_off) else $error("handler while off");
	property p_fatal; !cfg_out.mc_enable && fault.async_fatal && !fault.ambiguous |=> halted;
	endproperty
	a_fatal: assert property (p_fatal) else $error("fatal no shutdown");
	property p_drive; cfg_out.drive_off |=> !bus_reinit_n_oe; endproperty
	a_drive: assert property (p_drive) else $error("drove line");
	property p_ecc; fault.ecc_double && !fault.ambiguous && cfg_out.mc_enable && !halted
		|=> machine_check_event || halted; endproperty
	a_ecc: assert property (p_ecc) else $error("ecc lost");
	property p_amb; fault.ambiguous && !halted
		|=> !machine_check_event && (bus_reinit_n_oe || halted); endproperty
	a_amb: assert property (p_amb) else $error("ambiguous wrong");
	property p_lvl; machine_check_event && $past(fault.cache_err) |->
		cache_level_field == {$past(fault.cache_l2), !$past(fault.cache_l2)}; endproperty
	a_lvl: assert property (p_lvl) else $error("level wrong");
	property p_cfg; $past(resetn) && !$past(cfg_load) |-> $stable(cfg_out); endproperty
	a_cfg: assert property (p_cfg) else $error("config moved");
endmodule : mce_monitor
bind machine_check_bus_init_escalation mce_monitor mce_monitor_inst (.clock, .resetn,
	.cfg_load, .cfg_out, .fault, .bus_reinit_n_oe, .machine_check_event,
	.internal_fault_n, .halted, .cache_level_field);

/* File: test/tb_top.sv */
// Self-checking bench for the escalation unit
`timescale 1ns/100ps
module tb_top;
	import mc_escalation_pkg::*;
	logic       clock = 0, resetn = 0, cfg_load = 0, mc_done = 0, req = 0;
	logic       line, oe, drv, mce, ifn, clr, halted;
	cfg_s       cfg_in = '0, cfg_out;
	fault_s     fault = '0;
	logic [1:0] lvl;
	int         miscompares = 0, samples_checked = 0, seed = 96, i, r;
	always #2 clock = ~clock;
	machine_check_bus_init_escalation machine_check_bus_init_escalation_inst (.clock,
		.resetn, .cfg_load, .cfg_in, .fault, .mc_done, .bus_reinit_n_in(line),
		.bus_reinit_n_out(drv), .bus_reinit_n_oe(oe), .machine_check_event(mce),
		.internal_fault_n(ifn), .bus_iface_clear(clr), .halted, .cache_level_field(lvl),
		.cfg_out);
	partner_agent partner_agent_inst (.oe, .drv, .req, .line);
	task chk(input logic [2:0] seen, input logic [2:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %b want %b", $time, seen, exp);
		end
	endtask : chk
	task rst(input cfg_s c);
		@(posedge clock) resetn <= 0;
		repeat (6) @(posedge clock);
		resetn <= 1;
		cfg_load <= 1;
		cfg_in <= c;
		@(posedge clock) cfg_load <= 0;
		#1 chk(cfg_out, c);
	endtask : rst
	task pf(input fault_s f);
		@(posedge clock) fault <= f;
		@(posedge clock) fault <= '0;
		#1;
	endtask : pf
	task done;
		@(posedge clock) mc_done <= 1;
		@(posedge clock) mc_done <= 0;
	endtask : done
	task pin;
		@(posedge clock) req <= 1;
		repeat (8) @(posedge clock);
		req <= 0;
		#1;
	endtask : pin
	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial begin
		rst(3'h4);
		for (i = 0; i < 12; i++) begin
			r = $random(seed);
			pf({r[0], 2'h0, !r[0], r[1]});
			chk(mce, 1);
			chk(lvl, r[0] ? 2'h0 : {r[1], !r[1]});
			done;
		end
		pf(5'h08);
		chk({oe, clr, mce}, 3'h6);
		chk(drv, 0);
		repeat (8) @(posedge clock);
		done;
		pin;
		chk({halted, clr}, 3'h1);
		done;
		pf(5'h10);
		pf(5'h10);
		chk({halted, ifn, mce}, 3'h4);
		pf(5'h10);
		chk({halted, mce}, 3'h2);
		rst(3'h0);
		pf(5'h04);
		chk({halted, mce}, 3'h2);
		rst(3'h0);
		pin;
		chk(halted, 1);
		rst(3'h2);
		pin;
		chk({halted, clr}, 3'h0);
		rst(3'h5);
		pf(5'h08);
		chk({oe, halted}, 3'h1);
		print_verdict;
	end
endmodule : tb_top
